//--- logic/prs_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
`include "prs_cfg.svh"

module prs_supervisor #(
    parameter int TICK_CYC       = `PRS_TICK_CYC,
    parameter int HOLD_TICKS     = `PRS_HOLD_TICKS,
    parameter int PB_TICKS       = `PRS_PB_TICKS,
    parameter int WD_GND_TICKS   = `PRS_WD_GND_TICKS,
    parameter int WD_FLOAT_TICKS = `PRS_WD_FLOAT_TICKS,
    parameter int WD_VCC_TICKS   = `PRS_WD_VCC_TICKS
) (
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic       power_fail,
    input  wire logic       tolerance_select,
    input  wire logic [1:0] timeout_select,
    input  wire logic       pushbutton_reset_n,
    input  wire logic       watchdog_strobe_n,
    output var  logic       reset_out_q,
    output var  logic       reset_out_n_q,
    output var  logic       comparator_tol_q
);

    // ----------------------------------------
    // Timeout decode
    // ----------------------------------------
    // Nominal figures sit well above each minimum
    function automatic logic [`PRS_WD_W-1:0] wd_limit(input logic [1:0] tsel);
        case (tsel)
            `PRS_TSEL_GND:   wd_limit = `PRS_WD_W'(WD_GND_TICKS);
            `PRS_TSEL_FLOAT: wd_limit = `PRS_WD_W'(WD_FLOAT_TICKS);
            default:         wd_limit = `PRS_WD_W'(WD_VCC_TICKS);
        endcase
    endfunction

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    prs_pkg::prs_pins_s pins_raw;
    logic [`PRS_SYNC_W-1:0] sync1_q;
    logic [`PRS_SYNC_W-1:0] sync2_q;
    prs_pkg::prs_pins_s pins;

    assign pins_raw.power_fail         = power_fail;
    assign pins_raw.pushbutton_reset_n = pushbutton_reset_n;
    assign pins_raw.watchdog_strobe_n  = watchdog_strobe_n;
    assign pins_raw.tolerance_select   = tolerance_select;
    assign pins_raw.timeout_select     = timeout_select;

    // Idle levels at reset, so no false strobe edge follows reset
    localparam logic [`PRS_SYNC_W-1:0] SYNC_RST = `PRS_SYNC_RST;

    genvar gi;
    generate
        for (gi = 0; gi < `PRS_SYNC_W; gi++) begin : g_sync
            always_ff @(posedge clock) begin
                if (!resetn) begin
                    sync1_q[gi] <= SYNC_RST[gi];
                    sync2_q[gi] <= SYNC_RST[gi];
                end else begin
                    sync1_q[gi] <= pins_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    assign pins = sync2_q;

    // ----------------------------------------
    // Free-running timebase
    // ----------------------------------------
    logic [`PRS_TICK_W-1:0] tick_cnt_q;
    logic [`PRS_TICK_W-1:0] tick_cnt_d;
    logic                   tick_q;
    logic                   tick_d;

    always_comb begin
        tick_d     = 1'b0;
        tick_cnt_d = tick_cnt_q + `PRS_TICK_W'(1);
        if (tick_cnt_q == `PRS_TICK_W'(TICK_CYC - 1)) begin
            tick_cnt_d = '0;
            tick_d     = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
            tick_q     <= tick_d;
        end
    end

    // ----------------------------------------
    // Source filters
    // ----------------------------------------
    logic pf_level;
    logic pb_level;
    logic pf_f;
    logic pb_f;

    // Counted in clocks, not ticks: 2 us is far below one tick
    prs_debounce #(
        .STABLE_CNT (`PRS_PF_CYC),
        .RST_LEVEL  (1'b0)
    ) u_pf_filter (
        .clock   (clock),
        .resetn  (resetn),
        .step    (1'b1),
        .raw     (pins.power_fail),
        .level_q (pf_level)
    );

    // Half the 20 ms press budget, leaving room for tick phase
    prs_debounce #(
        .STABLE_CNT (PB_TICKS),
        .RST_LEVEL  (1'b1)
    ) u_pb_filter (
        .clock   (clock),
        .resetn  (resetn),
        .step    (tick_q),
        .raw     (pins.pushbutton_reset_n),
        .level_q (pb_level)
    );

    assign pf_f = pf_level;
    assign pb_f = !pb_level;

    // ----------------------------------------
    // Strobe edge detect
    // ----------------------------------------
    logic strobe_prev_q;
    logic strobe_fall;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            strobe_prev_q <= 1'b1;
        end else begin
            strobe_prev_q <= pins.watchdog_strobe_n;
        end
    end

    assign strobe_fall = strobe_prev_q && !pins.watchdog_strobe_n;

    // ----------------------------------------
    // Reset sequencer and watchdog
    // ----------------------------------------
    prs_pkg::prs_state_e    state_q;
    prs_pkg::prs_state_e    state_d;
    logic [`PRS_HOLD_W-1:0] hold_q;
    logic [`PRS_HOLD_W-1:0] hold_d;
    logic [`PRS_WD_W-1:0]   wd_q;
    logic [`PRS_WD_W-1:0]   wd_d;
    logic [`PRS_WD_W-1:0]   wd_lim;
    logic                   reset_d;
    logic                   src_active;

    assign wd_lim     = wd_limit(pins.timeout_select);
    assign src_active = pf_f || pb_f;

    always_comb begin
        state_d = state_q;
        hold_d  = hold_q;
        wd_d    = wd_q;
        case (state_q)
            prs_pkg::prs_st_hold: begin
                wd_d = '0;
                if (src_active) begin
                    hold_d = '0;
                end else if (tick_q) begin
                    // First tick may be partial, so one extra keeps the minimum
                    if (hold_q == `PRS_HOLD_W'(HOLD_TICKS)) begin
                        state_d = prs_pkg::prs_st_run;
                        hold_d  = '0;
                    end else begin
                        hold_d = hold_q + `PRS_HOLD_W'(1);
                    end
                end
            end
            prs_pkg::prs_st_run: begin
                // No path out of here except into reset
                if (src_active) begin
                    state_d = prs_pkg::prs_st_hold;
                    wd_d    = '0;
                end else if (strobe_fall) begin
                    wd_d = '0;
                end else if (tick_q) begin
                    if (wd_q >= wd_lim - `PRS_WD_W'(1)) begin
                        state_d = prs_pkg::prs_st_hold;
                        wd_d    = '0;
                    end else begin
                        wd_d = wd_q + `PRS_WD_W'(1);
                    end
                end
            end
            default: begin
                state_d = prs_pkg::prs_st_hold;
                hold_d  = '0;
                wd_d    = '0;
            end
        endcase
    end

    assign reset_d = (state_d != prs_pkg::prs_st_run);

    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_q          <= prs_pkg::prs_st_hold;
            hold_q           <= '0;
            wd_q             <= '0;
            reset_out_q      <= 1'b1;
            reset_out_n_q    <= 1'b0;
            comparator_tol_q <= 1'b0;
        end else begin
            state_q          <= state_d;
            hold_q           <= hold_d;
            wd_q             <= wd_d;
            reset_out_q      <= reset_d;
            reset_out_n_q    <= !reset_d;
            comparator_tol_q <= pins.tolerance_select;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_release;
        reset_out_q ##1 !reset_out_q;
    endsequence

    sequence s_expire;
        state_q == prs_pkg::prs_st_run && tick_q && !src_active && !strobe_fall
            && wd_q == wd_lim - `PRS_WD_W'(1);
    endsequence

    AST_PF_FORCE: assert property (@(posedge clock) disable iff (!resetn)
        pf_f |=> reset_out_q && !reset_out_n_q)
        else $error("power fail did not force resets");

    AST_COMPLEMENT: assert property (@(posedge clock) disable iff (!resetn)
        reset_out_q != reset_out_n_q)
        else $error("reset outputs disagree");

    AST_PB_FORCE: assert property (@(posedge clock) disable iff (!resetn)
        pb_f |=> reset_out_q)
        else $error("pushbutton did not force resets");

    AST_HOLD_MIN: assert property (@(posedge clock) disable iff (!resetn)
        s_release |-> $past(tick_q) && $past(hold_q) == `PRS_HOLD_W'(HOLD_TICKS)
            && !$past(src_active))
        else $error("resets released before full hold");

    AST_WD_START: assert property (@(posedge clock) disable iff (!resetn)
        reset_out_q |-> wd_q == '0)
        else $error("watchdog counted during reset");

    AST_WD_CLEAR: assert property (@(posedge clock) disable iff (!resetn)
        (state_q == prs_pkg::prs_st_run && strobe_fall && !src_active)
            |=> wd_q == '0 && !reset_out_q)
        else $error("strobe did not restart watchdog");

    AST_WD_EXPIRE: assert property (@(posedge clock) disable iff (!resetn)
        s_expire |=> reset_out_q ##1 reset_out_q)
        else $error("watchdog expiry missed");

    AST_WD_RUNS: assert property (@(posedge clock) disable iff (!resetn)
        (state_q == prs_pkg::prs_st_run && tick_q && !src_active && !strobe_fall
            && wd_q < wd_lim - `PRS_WD_W'(1)) |=> wd_q == $past(wd_q) + `PRS_WD_W'(1))
        else $error("watchdog stalled while running");

    AST_OVERLAP: assert property (@(posedge clock) disable iff (!resetn)
        src_active |=> hold_q == '0 && reset_out_q)
        else $error("hold advanced with a source still active");

endmodule // prs_supervisor

`default_nettype wire

//--- logic/prs_cfg.svh
`ifndef PRS_CFG_SVH
`define PRS_CFG_SVH

// ----------------------------------------
// Timebase
// ----------------------------------------
`define PRS_CLK_MHZ             10
`define PRS_TICK_US             100
`define PRS_TICK_CYC            (`PRS_CLK_MHZ * `PRS_TICK_US)
`define PRS_TICK_W              10

// ----------------------------------------
// Reset hold and pushbutton timing
// ----------------------------------------
`define PRS_HOLD_MS             250
`define PRS_HOLD_TICKS          (`PRS_HOLD_MS * 1000 / `PRS_TICK_US)
`define PRS_HOLD_W              12
`define PRS_PRESS_TO_RESET_DELAY_MS 20
`define PRS_PB_DEBOUNCE_MS      10
`define PRS_PB_TICKS            (`PRS_PB_DEBOUNCE_MS * 1000 / `PRS_TICK_US)

// ----------------------------------------
// Power-fail glitch filter
// ----------------------------------------
`define PRS_PF_GLITCH_NS        2000
`define PRS_PF_CYC              ((`PRS_PF_GLITCH_NS * `PRS_CLK_MHZ + 999) / 1000)
`define PRS_DB_W                8

// ----------------------------------------
// Watchdog timeouts
// ----------------------------------------
`define PRS_WD_GND_MS           150
`define PRS_WD_FLOAT_MS         600
`define PRS_WD_VCC_MS           1200
`define PRS_WD_GND_TICKS        (`PRS_WD_GND_MS * 1000 / `PRS_TICK_US)
`define PRS_WD_FLOAT_TICKS      (`PRS_WD_FLOAT_MS * 1000 / `PRS_TICK_US)
`define PRS_WD_VCC_TICKS        (`PRS_WD_VCC_MS * 1000 / `PRS_TICK_US)
`define PRS_WD_W                14
`define PRS_TSEL_GND            2'h0
`define PRS_TSEL_FLOAT          2'h1
`define PRS_TSEL_VCC            2'h2

// ----------------------------------------
// Synchroniser reset: buttons and strobe idle high
// ----------------------------------------
`define PRS_SYNC_W              6
`define PRS_SYNC_RST            6'h18

`endif

//--- logic/prs_pkg.sv
`default_nettype none

package prs_pkg;

    typedef enum logic {
        prs_st_hold,
        prs_st_run
    } prs_state_e;

    typedef struct packed {
        logic       power_fail;
        logic       pushbutton_reset_n;
        logic       watchdog_strobe_n;
        logic       tolerance_select;
        logic [1:0] timeout_select;
    } prs_pins_s;

endpackage

`default_nettype wire

//--- logic/prs_debounce.sv
`timescale 1ns/1ps
`default_nettype none
`include "prs_cfg.svh"

module prs_debounce #(
    parameter int   STABLE_CNT = 1,
    parameter logic RST_LEVEL  = 1'b0
) (
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic step,
    input  wire logic raw,
    output var  logic level_q
);

    logic [`PRS_DB_W-1:0] cnt_q;
    logic [`PRS_DB_W-1:0] cnt_d;
    logic                 level_d;

    // ----------------------------------------
    // Level accepted only after a full stable run
    // ----------------------------------------
    always_comb begin
        cnt_d   = cnt_q;
        level_d = level_q;
        if (raw == level_q) begin
            cnt_d = '0;
        end else if (step) begin
            if (cnt_q == `PRS_DB_W'(STABLE_CNT - 1)) begin
                level_d = raw;
                cnt_d   = '0;
            end else begin
                cnt_d = cnt_q + `PRS_DB_W'(1);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            cnt_q   <= '0;
            level_q <= RST_LEVEL;
        end else begin
            cnt_q   <= cnt_d;
            level_q <= level_d;
        end
    end

endmodule // prs_debounce

`default_nettype wire

//--- dv/prs_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Processor model: strobes the watchdog, receives the resets
// ----------------------------------------
module prs_cpu_model (
    input  wire logic       clock,
    input  wire logic       reset_out_q,
    input  wire logic       reset_out_n_q,
    input  wire logic       strobe_en,
    input  wire logic [7:0] period,
    output var  logic       watchdog_strobe_n,
    output var  logic [7:0] resets_seen
);
    logic [7:0] gap_q;
    logic       rst_seen_q;

    initial begin
        watchdog_strobe_n = 1'b1;
        resets_seen       = 8'h00;
        gap_q             = 8'h00;
        rst_seen_q        = 1'b0;
    end

    // A processor held in reset cannot strobe; its gap restarts on release
    always @(posedge clock) begin
        rst_seen_q <= reset_out_q;
        if (reset_out_q && !rst_seen_q) begin
            resets_seen <= resets_seen + 8'h01;
        end
        if (!strobe_en || reset_out_q || !reset_out_n_q) begin
            gap_q             <= 8'h00;
            watchdog_strobe_n <= 1'b1;
        end else begin
            gap_q             <= (gap_q >= period - 8'h01) ? 8'h00 : gap_q + 8'h01;
            watchdog_strobe_n <= (gap_q < period - 8'h02);
        end
    end
endmodule // prs_cpu_model

`default_nettype wire

//--- dv/test_processor_reset_supervisor.sv
`timescale 1ns/1ps
`default_nettype none

`define PRS_CHK(name, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("[ERR] %s expected %0h seen %0h", name, exp, got); \
        end \
    end

module test_processor_reset_supervisor;
    // ----------------------------------------
    // Shortened counts keep the run small
    // ----------------------------------------
    localparam int TICK = 4;
    localparam int HOLD = 5;
    localparam int PB   = 2;
    localparam int WGND = 8;
    localparam int WFLT = 12;
    localparam int WVCC = 20;

    logic       clock;
    logic       resetn;
    logic       power_fail;
    logic       tolerance_select;
    logic [1:0] timeout_select;
    logic       pushbutton_reset_n;
    logic       watchdog_strobe_n;
    logic       reset_out_q;
    logic       reset_out_n_q;
    logic       tol_q;
    logic       strobe_en;
    logic [7:0] period;
    logic [7:0] resets_seen;
    int         mismatches;
    int         total_checks;

    prs_supervisor #(.TICK_CYC(TICK), .HOLD_TICKS(HOLD), .PB_TICKS(PB), .WD_GND_TICKS(WGND),
                     .WD_FLOAT_TICKS(WFLT), .WD_VCC_TICKS(WVCC)) dut_u (
        .clock             (clock),
        .resetn            (resetn),
        .power_fail        (power_fail),
        .tolerance_select  (tolerance_select),
        .timeout_select    (timeout_select),
        .pushbutton_reset_n(pushbutton_reset_n),
        .watchdog_strobe_n (watchdog_strobe_n),
        .reset_out_q       (reset_out_q),
        .reset_out_n_q     (reset_out_n_q),
        .comparator_tol_q  (tol_q)
    );

    prs_cpu_model cpu_u (
        .clock            (clock),
        .reset_out_q      (reset_out_q),
        .reset_out_n_q    (reset_out_n_q),
        .strobe_en        (strobe_en),
        .period           (period),
        .watchdog_strobe_n(watchdog_strobe_n),
        .resets_seen      (resets_seen)
    );

    always #50 clock = ~clock;

    always @(negedge clock) begin
        `PRS_CHK("complement", ~reset_out_q, reset_out_n_q)
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic wait_rst(input logic lvl, input int lim, output int n);
        n = 0;
        while (reset_out_q !== lvl && n < lim) begin
            @(negedge clock);
            n++;
        end
    endtask

    task automatic stay(input logic lvl, input int cyc, output int bad);
        bad = 0;
        repeat (cyc) begin
            @(negedge clock);
            if (reset_out_q !== lvl) bad++;
        end
    endtask

    task automatic in_range(input string what, input int n, input int lo, input int hi);
        `PRS_CHK(what, 1'b1, (n >= lo && n <= hi))
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_powerup();
        int n;
        wait_rst(1'b0, 60, n);
        in_range("powerup_hold", n, HOLD * TICK, (HOLD + 1) * TICK + 4);
        tolerance_select = 1'b1;
        repeat (4) @(negedge clock);
        `PRS_CHK("tol_pass_high", 1'b1, tol_q)
        tolerance_select = 1'b0;
        repeat (4) @(negedge clock);
        `PRS_CHK("tol_pass_low", 1'b0, tol_q)
        $display("test powerup done");
    endtask

    task automatic t_watchdog();
        int n;
        int lim [4] = '{WGND, WFLT, WVCC, WVCC};
        for (int i = 0; i < 4; i++) begin
            wait_rst(1'b1, 100, n);
            timeout_select = 2'(i);
            wait_rst(1'b0, 40, n);
            in_range("wd_hold", n, HOLD * TICK, (HOLD + 1) * TICK + 4);
            wait_rst(1'b1, 100, n);
            in_range("wd_expiry", n, (lim[i] - 1) * TICK, lim[i] * TICK + 4);
        end
        $display("test watchdog done");
    endtask

    task automatic t_strobe();
        int n;
        int bad;
        timeout_select = 2'h0;
        strobe_en      = 1'b1;
        wait_rst(1'b0, 40, n);
        stay(1'b0, 200, bad);
        `PRS_CHK("strobe_keeps_alive", 0, bad)
        strobe_en = 1'b0;
        wait_rst(1'b1, WGND * TICK + 4, n);
        `PRS_CHK("reset_after_strobe_stop", 1'b1, reset_out_q)
        $display("test strobe done");
    endtask

    task automatic t_powerfail();
        int n;
        int bad;
        strobe_en = 1'b1;
        wait_rst(1'b0, 60, n);
        power_fail = 1'b1;
        repeat (10) @(negedge clock);
        power_fail = 1'b0;
        stay(1'b0, 30, bad);
        `PRS_CHK("short_pf_ignored", 0, bad)
        power_fail = 1'b1;
        wait_rst(1'b1, 40, n);
        in_range("pf_assert_delay", n, 20, 27);
        stay(1'b1, 60, bad);
        `PRS_CHK("pf_held", 0, bad)
        power_fail = 1'b0;
        wait_rst(1'b0, 80, n);
        in_range("pf_release_hold", n, 20 + HOLD * TICK, 24 + (HOLD + 1) * TICK + 4);
        $display("test powerfail done");
    endtask

    task automatic t_pushbutton();
        int         n;
        int         bad;
        logic [7:0] seen;
        pushbutton_reset_n = 1'b0;
        repeat (3) @(negedge clock);
        pushbutton_reset_n = 1'b1;
        stay(1'b0, 20, bad);
        `PRS_CHK("bounce_ignored", 0, bad)
        seen               = resets_seen;
        pushbutton_reset_n = 1'b0;
        wait_rst(1'b1, 30, n);
        in_range("press_to_reset_delay", n, (PB - 1) * TICK, (PB + 1) * TICK + 6);
        stay(1'b1, 30, bad);
        `PRS_CHK("held_while_pressed", 0, bad)
        pushbutton_reset_n = 1'b1;
        wait_rst(1'b0, 60, n);
        in_range("release_to_drop", n, (PB + HOLD - 1) * TICK, (PB + HOLD + 2) * TICK + 6);
        `PRS_CHK("one_pulse_per_press", seen + 8'h01, resets_seen)
        $display("test pushbutton done");
    endtask

    // ----------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------
    initial begin
        clock              = 1'b0;
        resetn             = 1'b0;
        power_fail         = 1'b0;
        tolerance_select   = 1'b0;
        timeout_select     = 2'h0;
        pushbutton_reset_n = 1'b1;
        strobe_en          = 1'b0;
        period             = 8'(3 * TICK);
        mismatches         = 0;
        total_checks       = 0;
        repeat (3) @(negedge clock);
        resetn = 1'b1;
        t_powerup();
        t_watchdog();
        t_strobe();
        t_powerfail();
        t_pushbutton();
        report_and_stop();
    end

    // Whole run is under 1000 clocks; six times that means a hang
    initial begin
        #600_000;
        mismatches++;
        $display("watchdog expired");
        report_and_stop();
    end
endmodule // test_processor_reset_supervisor

`default_nettype wire
